// >>> hdl/isa_master_cycle.sv
// isa bus master cycle sequencer with minimum T spacing
// Contract
// - 16-bit I/O write keeps SA valid 19 T after IOW asserted; requests with req_short_i set skip this hold.
// - at least 10 T from command assertion to next ALE.
// - same command class asserted at least 12 T apart.
// - at least 3 T from any command negation to next command.
// - at least 1 T from command negation to next ALE.
// - IOCHRDY wait from slave honoured; 8 T/14 T after LA.
// - read data not sampled before 8 T/14 T after LA valid.
// - IOCHRDY negation taken only from 6 T/12 T after ALE.
// - read data not sampled before 4 T/10 T after ALE.
// - ALE asserted at least 2 T before memory command.
// - memory command held at least 9 T before negation.
`timescale 1ns/10ps
`default_nettype none
module isa_master_cycle
    import isa_timing_pkg::*;
#(
    parameter int unsigned ADDR_W = 24,
    parameter int unsigned DATA_W = 16
) (
    // clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // request
    input wire logic req_i,
    input wire logic [1:0] req_class_i,
    input wire logic req_write_i,
    input wire logic req_wide_i,
    input wire logic req_short_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    // isa pins
    output logic ale_n_o,
    output logic memr_n_o,
    output logic memw_n_o,
    output logic smemr_n_o,
    output logic smemw_n_o,
    output logic ior_n_o,
    output logic iow_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic addr_valid_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic iochrdy_i
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic rdy_s1_r, rdy_s2_r;
    logic [DATA_W-1:0] din_s1_r, din_s2_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_s1_r <= 1'b1;
            rdy_s2_r <= 1'b1;
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else if (ce_i) begin
            rdy_s1_r <= iochrdy_i;
            rdy_s2_r <= rdy_s1_r;
            din_s1_r <= data_i;
            din_s2_r <= din_s1_r;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] pick(input logic wide, input logic [CNT_W-1:0] v16,
                                              input logic [CNT_W-1:0] v8);
        pick = wide ? v16 : v8;
    endfunction

    function automatic logic reached(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
        reached = (cnt >= lim);
    endfunction

    // ------------------------------------------------------------
    // elapsed-time counters
    // ------------------------------------------------------------
    logic [CNT_W-1:0] st_cnt;
    logic [CNT_W-1:0] neg_cnt;
    logic [CNT_W-1:0] cls_cnt [3];
    logic st_clr, neg_clr;
    logic [2:0] cls_clr;

    isa_sat_counter u_state_cnt (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .clear_i(st_clr), .count_o(st_cnt)
    );
    isa_sat_counter u_neg_cnt (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .clear_i(neg_clr), .count_o(neg_cnt)
    );
    for (genvar g = 0; g < 3; g++) begin : g_cls
        isa_sat_counter u_cls_cnt (
            .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .clear_i(cls_clr[g]),
            .count_o(cls_cnt[g])
        );
    end

    // ------------------------------------------------------------
    // cycle state machine
    // ------------------------------------------------------------
    bus_state_type state_r, state_nxt;
    logic [1:0] cls_r, cls_nxt;
    logic write_r, write_nxt, wide_r, wide_nxt, short_r, short_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [CNT_W-1:0] since_ale_r, since_ale_nxt;
    logic [CNT_W-1:0] since_cmd_r, since_cmd_nxt;
    logic ale_n_r, ale_n_nxt, cmd_on_r, cmd_on_nxt, done_r, done_nxt;
    logic addr_valid_r, addr_valid_nxt, ready_r, ready_nxt;
    logic wait_ok, data_ok, end_ok, ale_ok, cmd_ok, hold_ok;

    always_comb begin
        state_nxt = state_r;
        cls_nxt = cls_r;
        write_nxt = write_r;
        wide_nxt = wide_r;
        short_nxt = short_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        ale_n_nxt = ale_n_r;
        cmd_on_nxt = cmd_on_r;
        addr_valid_nxt = addr_valid_r;
        done_nxt = 1'b0;
        st_clr = 1'b0;
        neg_clr = 1'b0;
        cls_clr = 3'b000;
        since_ale_nxt = (since_ale_r == CNT_MAX) ? since_ale_r : since_ale_r + CNT_ONE;
        since_cmd_nxt = (since_cmd_r == CNT_MAX) ? since_cmd_r : since_cmd_r + CNT_ONE;
        // wait states accepted only once slave window opens
        wait_ok = reached(since_ale_r, pick(wide_r, T_ALE_RDY_16, T_ALE_RDY_8))
                  && (cls_r == CLS_IO
                      || reached(since_ale_r, pick(wide_r, T_LA_RDY_16, T_LA_RDY_8)));
        // read data window opens; synchroniser delay pushes it one cycle later
        data_ok = reached(since_ale_r,
                          pick(wide_r, T_ALE_DATA_16, T_ALE_DATA_8) + T_SYNC_LAG)
                  && (cls_r == CLS_IO
                      || reached(since_ale_r,
                                 pick(wide_r, T_LA_DATA_16, T_LA_DATA_8) + T_SYNC_LAG));
        end_ok = reached(since_cmd_r, T_CMD_ACTIVE)
                 && data_ok && !(wait_ok && !rdy_s2_r);
        ale_ok = reached(neg_cnt, T_NEG_TO_ALE);
        cmd_ok = reached(neg_cnt, T_NEG_TO_CMD)
                 && reached(cls_cnt[cls_r], T_CMD_TO_CMD);
        hold_ok = reached(since_cmd_r, T_CMD_TO_ALE)
                  && !(cls_r == CLS_IO && write_r && wide_r && !short_r
                       && !reached(since_cmd_r, T_IOW_ADDR_HOLD));
        ready_nxt = (state_nxt == ST_IDLE);
        case (state_r)
            ST_IDLE: begin
                if (req_i && ale_ok) begin
                    cls_nxt = req_class_i;
                    write_nxt = req_write_i;
                    wide_nxt = req_wide_i;
                    short_nxt = req_short_i;
                    addr_nxt = req_addr_i;
                    wdata_nxt = req_wdata_i;
                    addr_valid_nxt = 1'b1;
                    ale_n_nxt = 1'b0;
                    since_ale_nxt = '0;
                    st_clr = 1'b1;
                    state_nxt = ST_ALE;
                end
            end
            ST_ALE: begin
                if (reached(st_cnt, T_ALE_WIDTH)) begin
                    ale_n_nxt = 1'b1;
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (reached(since_ale_r, T_ALE_TO_CMD) && cmd_ok) begin
                    cmd_on_nxt = 1'b1;
                    since_cmd_nxt = '0;
                    cls_clr[cls_r] = 1'b1;
                    state_nxt = ST_CMD;
                end
            end
            ST_CMD: begin
                if (end_ok) begin
                    cmd_on_nxt = 1'b0;
                    neg_clr = 1'b1;
                    if (!write_r) begin
                        rdata_nxt = din_s2_r;
                    end
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hold_ok) begin
                    addr_valid_nxt = 1'b0;
                    done_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        ready_nxt = (state_nxt == ST_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cls_r <= CLS_MEM;
            write_r <= 1'b0;
            wide_r <= 1'b0;
            short_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            since_ale_r <= CNT_MAX;
            since_cmd_r <= CNT_MAX;
            ale_n_r <= 1'b1;
            cmd_on_r <= 1'b0;
            addr_valid_r <= 1'b0;
            done_r <= 1'b0;
            ready_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cls_r <= cls_nxt;
            write_r <= write_nxt;
            wide_r <= wide_nxt;
            short_r <= short_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            since_ale_r <= since_ale_nxt;
            since_cmd_r <= since_cmd_nxt;
            ale_n_r <= ale_n_nxt;
            cmd_on_r <= cmd_on_nxt;
            addr_valid_r <= addr_valid_nxt;
            done_r <= done_nxt;
            ready_r <= ready_nxt;
        end
    end

    // ------------------------------------------------------------
    // strobe outputs, registered
    // ------------------------------------------------------------
    logic memr_n_r, memw_n_r, smemr_n_r, smemw_n_r, ior_n_r, iow_n_r, oe_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            memr_n_r <= 1'b1;
            memw_n_r <= 1'b1;
            smemr_n_r <= 1'b1;
            smemw_n_r <= 1'b1;
            ior_n_r <= 1'b1;
            iow_n_r <= 1'b1;
            oe_r <= 1'b0;
        end else if (ce_i) begin
            memr_n_r <= !(cmd_on_nxt && cls_nxt == CLS_MEM && !write_nxt);
            memw_n_r <= !(cmd_on_nxt && cls_nxt == CLS_MEM && write_nxt);
            smemr_n_r <= !(cmd_on_nxt && cls_nxt == CLS_SMEM && !write_nxt);
            smemw_n_r <= !(cmd_on_nxt && cls_nxt == CLS_SMEM && write_nxt);
            ior_n_r <= !(cmd_on_nxt && cls_nxt == CLS_IO && !write_nxt);
            iow_n_r <= !(cmd_on_nxt && cls_nxt == CLS_IO && write_nxt);
            oe_r <= write_nxt && addr_valid_nxt && state_nxt != ST_ALE;
        end
    end

    assign memr_n_o = memr_n_r;
    assign memw_n_o = memw_n_r;
    assign smemr_n_o = smemr_n_r;
    assign smemw_n_o = smemw_n_r;
    assign ior_n_o = ior_n_r;
    assign iow_n_o = iow_n_r;
    assign data_oe_o = oe_r;
    assign data_o = wdata_r;
    assign ale_n_o = ale_n_r;
    assign addr_o = addr_r;
    assign addr_valid_o = addr_valid_r;
    assign rdata_o = rdata_r;
    assign done_o = done_r;
    assign req_ready_o = ready_r;

endmodule
`default_nettype wire

// >>> hdl/isa_sat_counter.sv
// saturating up counter used for elapsed-time tracking
`timescale 1ns/10ps
`default_nettype none
module isa_sat_counter
    import isa_timing_pkg::*;
#(
    parameter int unsigned WIDTH = CNT_W
) (
    // clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // control
    input wire logic clear_i,
    output logic [WIDTH-1:0] count_o
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (clear_i) begin
            count_nxt = '0;
        end else if (count_r != '1) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= '1;
        end else if (ce_i) begin
            count_r <= count_nxt;
        end
    end

    assign count_o = count_r;

endmodule
`default_nettype wire

// >>> inc/isa_timing_pkg.sv
// isa master cycle timing constants and types
package isa_timing_pkg;

    // all timing figures are whole T periods of the sequencing clock
    localparam int unsigned CNT_W = 6;
    localparam logic [5:0] T_ALE_WIDTH = 6'h01;
    localparam logic [5:0] T_ALE_TO_CMD = 6'h02;
    localparam logic [5:0] T_CMD_ACTIVE = 6'h09;
    localparam logic [5:0] T_CMD_TO_ALE = 6'h0A;
    localparam logic [5:0] T_CMD_TO_CMD = 6'h0C;
    localparam logic [5:0] T_NEG_TO_CMD = 6'h03;
    localparam logic [5:0] T_NEG_TO_ALE = 6'h01;
    localparam logic [5:0] T_IOW_ADDR_HOLD = 6'h13;
    localparam logic [5:0] T_LA_RDY_16 = 6'h08;
    localparam logic [5:0] T_LA_RDY_8 = 6'h0E;
    localparam logic [5:0] T_LA_DATA_16 = 6'h08;
    localparam logic [5:0] T_LA_DATA_8 = 6'h0E;
    localparam logic [5:0] T_ALE_RDY_16 = 6'h06;
    localparam logic [5:0] T_ALE_RDY_8 = 6'h0C;
    localparam logic [5:0] T_ALE_DATA_16 = 6'h04;
    localparam logic [5:0] T_ALE_DATA_8 = 6'h0A;
    // pin data reaches the read register one cycle behind the elapsed count
    localparam logic [5:0] T_SYNC_LAG = 6'h01;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [5:0] CNT_MAX = 6'h3F;

    typedef enum logic [1:0] {
        CLS_MEM = 2'b00,
        CLS_SMEM = 2'b01,
        CLS_IO = 2'b10
    } cmd_class_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ALE = 3'b001,
        ST_SETUP = 3'b010,
        ST_CMD = 3'b011,
        ST_HOLD = 3'b100
    } bus_state_type;

endpackage

// >>> tb/isa_master_cycle_chk.sv
// timing assertions for the isa master cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module isa_master_cycle_chk
    import isa_timing_pkg::*;
(
    // clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // request
    input wire logic req_i,
    input wire logic [1:0] req_class_i,
    input wire logic req_write_i,
    input wire logic req_wide_i,
    input wire logic req_short_i,
    input wire logic req_ready_o,
    // isa pins
    input wire logic ale_n_o,
    input wire logic memr_n_o,
    input wire logic memw_n_o,
    input wire logic smemr_n_o,
    input wire logic smemw_n_o,
    input wire logic ior_n_o,
    input wire logic iow_n_o,
    input wire logic addr_valid_o,
    input wire logic iochrdy_i
);
    logic [2:0] act, act_d_r;
    logic cmd, cmd_d_r, ale_d_r, wide_r, short_r, wr_r;
    logic [1:0] cls_r;
    logic [5:0] ev, rd_min;
    logic [5:0] c_r [6];
    assign act = {~(ior_n_o & iow_n_o), ~(smemr_n_o & smemw_n_o), ~(memr_n_o & memw_n_o)};
    assign cmd = |act;
    // ev: ale, cmd on, cmd off, mem on, smem on, io on
    assign ev = {act & ~act_d_r, ~cmd & cmd_d_r, cmd & ~cmd_d_r, ale_d_r & ~ale_n_o};
    assign rd_min = (cls_r == CLS_IO) ? (wide_r ? T_ALE_DATA_16 : T_ALE_DATA_8) :
        (wide_r ? T_LA_DATA_16 : T_LA_DATA_8);
    // cycles since each event, saturating
    always_ff @(posedge clk_i) begin
        ale_d_r <= ale_n_o | rst_i;
        act_d_r <= rst_i ? 3'h0 : act;
        cmd_d_r <= cmd & ~rst_i;
        if (ce_i && req_i && req_ready_o) begin
            {cls_r, wr_r, wide_r, short_r} <= {req_class_i, req_write_i, req_wide_i, req_short_i};
        end
        for (int k = 0; k < 6; k++) begin
            if (rst_i) c_r[k] <= CNT_MAX;
            else if (ev[k]) c_r[k] <= CNT_ONE;
            else if (c_r[k] != CNT_MAX) c_r[k] <= c_r[k] + CNT_ONE;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_iow_addr_hold: assert property ($fell(addr_valid_o) && cls_r == CLS_IO && wr_r
        && wide_r && !short_r |-> c_r[1] >= T_IOW_ADDR_HOLD) else $error("io address dropped early");
    a_cmd_ale_gap: assert property (ev[0] |-> c_r[1] >= T_CMD_TO_ALE)
        else $error("ale too soon after command");
    a_class_gap: assert property ((!ev[3] || c_r[3] >= T_CMD_TO_CMD) && (!ev[4] ||
        c_r[4] >= T_CMD_TO_CMD) && (!ev[5] || c_r[5] >= T_CMD_TO_CMD)) else $error("class gap short");
    a_neg_cmd_gap: assert property (ev[1] |-> c_r[2] >= T_NEG_TO_CMD)
        else $error("command too soon after negation");
    a_neg_ale_gap: assert property (ev[0] |-> !cmd && !$past(cmd))
        else $error("ale too close to command");
    a_ale_mem_lead: assert property (ev[3] |-> c_r[0] >= T_ALE_TO_CMD)
        else $error("memory command too soon after ale");
    a_mem_width: assert property (act_d_r[0] && !act[0] |-> c_r[3] >= T_CMD_ACTIVE)
        else $error("memory command too short");
    // data latched at negation left the pins two cycles earlier
    a_read_sample: assert property (ev[2] && !wr_r |-> c_r[0] >= rd_min + 6'h02)
        else $error("read ended before data window");
    a_wait_held: assert property (ev[2] && c_r[0] >= 6'h10 |->
        $past(iochrdy_i) || $past(iochrdy_i, 2) || $past(iochrdy_i, 3)) else $error("wait ignored");
    c_io_write: cover property (ev[5] && wr_r && wide_r);
    c_wait: cover property (cmd && !iochrdy_i);
    c_narrow_read: cover property (ev[2] && !wr_r && !wide_r);
endmodule
bind isa_master_cycle isa_master_cycle_chk isa_master_cycle_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .req_i(req_i), .req_class_i(req_class_i), .req_write_i(req_write_i),
    .req_wide_i(req_wide_i), .req_short_i(req_short_i), .req_ready_o(req_ready_o),
    .ale_n_o(ale_n_o), .memr_n_o(memr_n_o), .memw_n_o(memw_n_o), .smemr_n_o(smemr_n_o),
    .smemw_n_o(smemw_n_o), .ior_n_o(ior_n_o), .iow_n_o(iow_n_o), .addr_valid_o(addr_valid_o),
    .iochrdy_i(iochrdy_i));
`default_nettype wire

// >>> tb/isa_master_cycle_tb.sv
// self-checking bench for the isa master cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module isa_master_cycle_tb
    import isa_timing_pkg::*;
;
    logic clk_i = 0, rst_i = 1, ce_i = 1, req_i = 0, req_write_i = 0, req_wide_i = 0;
    logic req_short_i = 0, req_ready_o, done_o, ale_n_o, memr_n_o, memw_n_o, smemr_n_o;
    logic smemw_n_o, ior_n_o, iow_n_o, addr_valid_o, data_oe_o, iochrdy_i, s_wide = 1;
    logic [1:0] req_class_i = 0;
    logic [23:0] req_addr_i = 0, addr_o;
    logic [15:0] req_wdata_i = 0, rdata_o, data_o, data_i;
    logic [5:0] s_wait = 0;
    int n_mismatch = 0, n_compared = 0, cycles = 0, low_cnt = 0, len_s, len_h;
    isa_master_cycle isa_master_cycle_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .req_i(req_i), .req_class_i(req_class_i), .req_write_i(req_write_i),
        .req_wide_i(req_wide_i), .req_short_i(req_short_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .done_o(done_o),
        .rdata_o(rdata_o), .ale_n_o(ale_n_o), .memr_n_o(memr_n_o), .memw_n_o(memw_n_o),
        .smemr_n_o(smemr_n_o), .smemw_n_o(smemw_n_o), .ior_n_o(ior_n_o), .iow_n_o(iow_n_o),
        .addr_o(addr_o), .addr_valid_o(addr_valid_o), .data_o(data_o), .data_oe_o(data_oe_o),
        .data_i(data_i), .iochrdy_i(iochrdy_i));
    isa_slave_model isa_slave_model_i (.clk_i(clk_i), .rst_i(rst_i), .wide_i(s_wide),
        .wait_i(s_wait), .ale_n_i(ale_n_o), .memr_n_i(memr_n_o), .smemr_n_i(smemr_n_o),
        .ior_n_i(ior_n_o), .addr_i(addr_o), .data_o(data_i), .iochrdy_o(iochrdy_i));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (!(memr_n_o && memw_n_o && smemr_n_o && smemw_n_o && ior_n_o && iow_n_o)) low_cnt++;
        if (cycles == 6000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run_cycle(input logic [1:0] c, input logic w, input logic wd, input logic sh,
        input logic [23:0] a, output int len);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        {req_class_i, req_write_i, req_wide_i, req_short_i, s_wide} = {c, w, wd, sh, wd};
        req_addr_i = a;
        req_wdata_i = ~a[15:0];
        req_i = 1'b1;
        low_cnt = 0;
        @(negedge clk_i);
        req_i = 1'b0;
        len = 1;
        while (done_o !== 1'b1 && len < 200) begin
            @(negedge clk_i);
            len++;
        end
        check("done", 1, done_o);
        check("released", 0, {addr_valid_o, data_oe_o});
        check("address", a, addr_o);
        if (w) check("write data", {16'h0000, ~a[15:0]}, data_o);
        if (!w) check("read data", a[15:0] ^ 16'hA5C3, rdata_o);
    endtask
    task automatic t_reset;
        check("idle pins", 32'h0000_01FC, {ale_n_o, memr_n_o, memw_n_o, smemr_n_o, smemw_n_o,
            ior_n_o, iow_n_o, addr_valid_o, done_o});
        check("ready", 1, req_ready_o);
        $display("test reset done");
    endtask
    task automatic t_all_kinds;
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 4; k++) begin
                run_cycle(c[1:0], k[0], k[1], 1'b0, 24'h01_2340 + 24'(c * 4 + k), len_s);
            end
        end
        $display("test all kinds done");
    endtask
    task automatic t_io_hold;
        run_cycle(CLS_IO, 1'b1, 1'b1, 1'b0, 24'h00_0300, len_s);
        check("io write length", 1, len_s > 19);
        run_cycle(CLS_IO, 1'b1, 1'b1, 1'b1, 24'h00_0302, len_h);
        check("short io write", 1, len_h < len_s);
        $display("test io hold done");
    endtask
    task automatic t_wait;
        s_wait = 6'h0A;
        run_cycle(CLS_MEM, 1'b0, 1'b1, 1'b0, 24'h0A_0010, len_s);
        check("wide wait length", 1, low_cnt >= 16);
        run_cycle(CLS_MEM, 1'b0, 1'b0, 1'b0, 24'h0A_0021, len_s);
        check("narrow wait length", 1, low_cnt >= 20);
        s_wait = 6'h00;
        $display("test wait done");
    endtask
    task automatic t_freeze;
        fork
            run_cycle(CLS_MEM, 1'b0, 1'b1, 1'b0, 24'h0B_0040, len_s);
            begin
                repeat (6) @(negedge clk_i);
                ce_i = 1'b0;
                repeat (4) @(negedge clk_i);
                ce_i = 1'b1;
            end
        join
        check("frozen strobe length", 1, low_cnt >= 32'(T_CMD_ACTIVE) + 32'd4);
        $display("test freeze done");
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 0;
        repeat (3) @(negedge clk_i);
        t_reset();
        t_all_kinds();
        t_io_hold();
        t_wait();
        t_freeze();
        end_sim();
    end
endmodule
`default_nettype wire

// >>> tb/isa_slave_model.sv
// isa slave model answering reads and stretching cycles on demand
`timescale 1ns/10ps
`default_nettype none
module isa_slave_model
    import isa_timing_pkg::*;
(
    // clocking
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control
    input wire logic wide_i,
    input wire logic [5:0] wait_i,
    // isa pins
    input wire logic ale_n_i,
    input wire logic memr_n_i,
    input wire logic smemr_n_i,
    input wire logic ior_n_i,
    input wire logic [23:0] addr_i,
    output logic [15:0] data_o,
    output logic iochrdy_o
);
    // count tracks cycles since ale exactly; lag covers the master's two synchroniser stages
    localparam logic [5:0] DET_LAG = 6'h02;
    logic ale_d_r;
    logic [5:0] cnt_r, ready_at, wait_at;
    logic [15:0] word;
    always_ff @(posedge clk_i) begin
        ale_d_r <= ale_n_i | rst_i;
        if (rst_i) cnt_r <= CNT_MAX;
        else if (ale_d_r && !ale_n_i) cnt_r <= CNT_ONE;
        else if (cnt_r != CNT_MAX) cnt_r <= cnt_r + CNT_ONE;
    end
    // invalid data changes every cycle so early sampling shows
    always_comb begin
        word = addr_i[15:0] ^ 16'hA5C3;
        ready_at = (!ior_n_i ? (wide_i ? T_ALE_DATA_16 : T_ALE_DATA_8) :
            (wide_i ? T_LA_DATA_16 : T_LA_DATA_8)) - DET_LAG;
        wait_at = (wide_i ? T_LA_RDY_16 : T_LA_RDY_8) - DET_LAG;
        data_o = ~word ^ {10'h000, cnt_r};
        if (!(memr_n_i && smemr_n_i && ior_n_i) && cnt_r >= ready_at) data_o = word;
        iochrdy_o = !(cnt_r >= wait_at && cnt_r < wait_at + wait_i);
    end
endmodule
`default_nettype wire
